// *** shared/hp_pkg.sv ***
`default_nettype none
package hp_pkg;
    // timing
    localparam int unsigned CLK_NS       = 25;
    localparam int unsigned RST_PULSE_NS = 125000;
    localparam int unsigned RST_CYC      = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WDOG_MS      = 128;
    localparam int unsigned WDOG_CYC     = WDOG_MS * 1000000 / CLK_NS;
    localparam logic [2:0]  WARM_DONE    = 3'h7;
    // serial header codes, bit 2 masked off
    localparam logic [7:0]  HDR_MASK     = 8'hFB;
    localparam logic [7:0]  HDR_CONST    = 8'h43;
    localparam logic [7:0]  HDR_MIX_NI   = 8'h41;
    localparam logic [7:0]  HDR_MIX_IL   = 8'h49;
    localparam int unsigned HDR_HALF_BIT = 2;
    localparam int unsigned ADR_RD_BIT   = 7;
    // fifo window and aliases
    localparam logic [7:0]  FIFO_TOP     = 8'h1F;
    localparam logic [7:0]  FIFO_AL0     = 8'h6A;
    localparam logic [7:0]  FIFO_AL1     = 8'h7A;
    // local registers
    localparam logic [7:0]  TOP_IRQ_STATUS_ADDR    = 8'hF8;
    localparam logic [7:0]  MASK_ADDR    = 8'hF9;
    localparam logic [7:0]  CFG_ADDR     = 8'hFA;
    localparam logic [7:0]  WDOG_ADDR    = 8'hFB;
    localparam logic [7:0]  MASK_RST     = 8'h00;
    localparam logic [2:0]  CFG_RST      = 3'h0;
    localparam int unsigned POL_BIT      = 2;
    localparam int unsigned AUX_BIT      = 0;
    // reset source select codes
    localparam logic [1:0]  SEL_NONE     = 2'h0;
    localparam logic [1:0]  SEL_RSVD     = 2'h1;
    localparam logic [1:0]  SEL_CIW      = 2'h2;
    localparam logic [1:0]  SEL_WDOG     = 2'h3;
    // watchdog key pairs {first, second}
    localparam logic [1:0]  KEY_STEP1    = 2'h2;
    localparam logic [1:0]  KEY_STEP2    = 2'h1;

    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic       serial_data_in;
        logic       wr_n;
        logic       rd_n;
        logic       ale;
        logic       wake_n;
        logic       addr_mode_pin;
        logic [7:0] a;
        logic [7:0] ad;
    } hp_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
        logic       fifo;
        logic [7:0] slot;
    } hp_req_t;

    typedef enum logic [2:0] {PH_HDR, PH_ADR, PH_DMY, PH_CRD, PH_WR, PH_IGN} hp_ph_t;

    typedef struct packed {
        hp_pins_t    sy1;
        hp_pins_t    sy2;
        hp_pins_t    sy3;
        hp_pins_t    flt;
        hp_pins_t    prv;
        logic [2:0]  wc;
        logic        mux_lk;
        logic [7:0]  la;
        logic [7:0]  ptr;
        logic        acc;
        logic        aw;
        logic [7:0]  pdo;
        logic        poe;
        logic        ld;
        hp_ph_t      ph;
        logic [7:0]  hdr;
        logic [7:0]  sh;
        logic [2:0]  bc;
        logic [7:0]  tx;
        logic        serial_data_out;
        logic [7:0]  wad;
        logic [7:0]  fptr;
        hp_req_t     q;
        logic [2:0]  cfg;
        logic [7:0]  mask;
        logic        wdog_overflow_flag;
        logic        irq;
        logic        wd_on;
        logic        wd_arm;
        logic [22:0] wd_cnt;
        logic [12:0] rp;
        logic        rst_n;
        logic        osc;
        logic [3:0]  ci;
    } hp_st_t;
endpackage
`default_nettype wire

// *** hw/hp_host_port.sv ***
// Operation
// - constant-address fifo addresses reach current slot; pointer advances per data byte.
// - non-interleaved mixed header: read pairs, then write address gives repeated writes.
// - interleaved mixed header: reads overlapped; write address gives repeated writes.
// - parallel bus style from address-latch pin: high, low, or toggling.
// - any address-latch edge locks multiplexed style until hardware reset.
// - non-multiplexed style takes access address from separate address lines.
// - multiplexed style latches address from shared lines on address-latch strobe.
// - addressing-mode pin low selects direct, high selects indirect addressing.
// - indirect mode uses address bit zero: pointer or data register.
// - top interrupt status holds eight source-group flags.
// - interrupt output stays active until all pending sources are cleared.
// - mask bits suppress matching status indications from the interrupt output.
// - mask all ones then restore produces a fresh interrupt edge.
// - reset-source code routes wake and code change only at code 2; watchdog expiry is routed under every code.
// - any internal reset source returns the configuration register to default.
// - selected code change gives a reset pulse of 125 to 250 us.
// - wake low restarts oscillator; when selected gives 125 to 250 us pulse.
// - selecting watchdog clears and starts the watchdog timer.
// - missed keys expire watchdog: overflow flag set, 125 us reset pulse.
// - watchdog stays active once started; only hardware reset stops it.
// - serial header bit 2 selects lower or upper 128 register locations.
// - serial port samples on rising clock, shifts out on falling, msb first.
// - interrupt output active low by default, programmable active high.
`timescale 1ns/1ps
`default_nettype none
module hp_host_port #(
    parameter int unsigned RST_PULSE_CYC = hp_pkg::RST_CYC,
    parameter int unsigned WDOG_LIM_CYC  = hp_pkg::WDOG_CYC
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // interface strap
    input  wire logic             serial_sel,
    // host pins
    input  wire hp_pkg::hp_pins_t pins,
    output logic                  serial_data_out,
    output logic [7:0]            ad_out,
    output logic                  ad_oe,
    output logic                  irq_pin,
    output logic                  reset_output_n,
    output logic                  osc_restart,
    // chip side
    input  wire logic [7:0]       irq_src,
    input  wire logic [3:0]       ci_code,
    input  wire logic [7:0]       reg_rdata,
    output hp_pkg::hp_req_t       reg_req
);
    localparam int unsigned PW = $bits(hp_pkg::hp_pins_t);

    hp_pkg::hp_st_t st_q;
    hp_pkg::hp_st_t st_d;
    logic [PW-1:0]  dif;
    logic [7:0]     stat;
    logic [7:0]     rdm;
    logic [7:0]     b;
    logic [7:0]     ht;
    logic [7:0]     ia;
    logic [7:0]     idat;
    logic [7:0]     base;
    logic           warm;
    logic           ird;
    logic           iwr;
    logic           ale_e;
    logic           cs_rise;
    logic           mot;
    logic           act;
    logic           isrd;
    logic           pend;
    logic           cic_f;
    logic           wake_f;
    logic           wd_f;
    logic           wd_sel;
    logic           fire;
    logic           route;

    always_comb begin
        st_d = st_q;
        ird = 1'b0;
        iwr = 1'b0;
        ia = st_q.wad;
        idat = 8'h00;
        b = {st_q.sh[6:0], st_q.flt.serial_data_in};
        ht = st_q.hdr & hp_pkg::HDR_MASK;
        warm = st_q.wc == hp_pkg::WARM_DONE;
        // pin filter: a change counts once stages two and three agree
        st_d.sy1 = pins;
        st_d.sy2 = st_q.sy1;
        st_d.sy3 = st_q.sy2;
        dif = st_q.sy2 ^ st_q.sy3;
        st_d.flt = hp_pkg::hp_pins_t'((st_q.sy3 & ~dif) | (st_q.flt & dif));
        st_d.prv = st_q.flt;
        if (!warm) begin
            st_d.wc = st_q.wc + 3'h1;
        end
        // top status and read mux
        stat = irq_src;
        stat[hp_pkg::AUX_BIT] = irq_src[hp_pkg::AUX_BIT] | st_q.wdog_overflow_flag;
        pend = |(stat & ~st_q.mask);
        case (st_q.q.addr)
            hp_pkg::TOP_IRQ_STATUS_ADDR: rdm = stat;
            hp_pkg::MASK_ADDR: rdm = st_q.mask;
            hp_pkg::CFG_ADDR:  rdm = {5'h00, st_q.cfg};
            default:           rdm = reg_rdata;
        endcase
        if (st_q.ld) begin
            st_d.tx = rdm;
            st_d.pdo = rdm;
            st_d.ld = 1'b0;
        end
        cs_rise = 1'b0;
        ale_e = 1'b0;
        mot = 1'b0;
        act = 1'b0;
        isrd = 1'b0;
        base = st_q.flt.a;
        if (warm && serial_sel) begin
            cs_rise = ~st_q.prv.cs_n & st_q.flt.cs_n;
            if (cs_rise) begin
                // partial byte is simply dropped
                st_d.ph = hp_pkg::PH_HDR;
                st_d.bc = 3'h0;
                st_d.fptr = 8'h00;
            end else if (!st_q.flt.cs_n && !st_q.prv.sclk && st_q.flt.sclk) begin
                st_d.sh = b;
                st_d.bc = st_q.bc + 3'h1;
                if (st_q.bc == 3'h7) begin
                    case (st_q.ph)
                        hp_pkg::PH_HDR: begin
                            st_d.hdr = b;
                            if ((b & hp_pkg::HDR_MASK) == hp_pkg::HDR_CONST ||
                                (b & hp_pkg::HDR_MASK) == hp_pkg::HDR_MIX_NI ||
                                (b & hp_pkg::HDR_MASK) == hp_pkg::HDR_MIX_IL) begin
                                st_d.ph = hp_pkg::PH_ADR;
                            end else begin
                                st_d.ph = hp_pkg::PH_IGN;
                            end
                        end
                        hp_pkg::PH_ADR: begin
                            ia = {st_q.hdr[hp_pkg::HDR_HALF_BIT], b[6:0]};
                            st_d.wad = ia;
                            if (b[hp_pkg::ADR_RD_BIT]) begin
                                ird = 1'b1;
                                if (ht == hp_pkg::HDR_CONST) begin
                                    st_d.ph = hp_pkg::PH_CRD;
                                end else if (ht == hp_pkg::HDR_MIX_NI) begin
                                    st_d.ph = hp_pkg::PH_DMY;
                                end
                                // interleaved: next address arrives while data leaves
                            end else begin
                                st_d.ph = hp_pkg::PH_WR;
                            end
                        end
                        hp_pkg::PH_DMY: st_d.ph = hp_pkg::PH_ADR;
                        hp_pkg::PH_CRD: begin
                            ird = 1'b1;
                            st_d.fptr = st_q.fptr + 8'h01;
                        end
                        hp_pkg::PH_WR: begin
                            iwr = 1'b1;
                            idat = b;
                            if (ht == hp_pkg::HDR_CONST) begin
                                st_d.fptr = st_q.fptr + 8'h01;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (!st_q.flt.cs_n && st_q.prv.sclk && !st_q.flt.sclk) begin
                st_d.serial_data_out = st_q.tx[7];
                st_d.tx = {st_q.tx[6:0], 1'b0};
            end
        end else if (warm) begin
            ale_e = st_q.flt.ale ^ st_q.prv.ale;
            if (ale_e) begin
                st_d.mux_lk = 1'b1;
            end
            if (st_q.prv.ale && !st_q.flt.ale) begin
                st_d.la = st_q.flt.ad;
            end
            base = st_q.mux_lk ? st_q.la : st_q.flt.a;
            mot = ~st_q.mux_lk & st_q.flt.ale;
            act = ~st_q.flt.cs_n & (mot ? ~st_q.flt.rd_n : ~(st_q.flt.rd_n & st_q.flt.wr_n));
            isrd = mot ? st_q.flt.wr_n : ~st_q.flt.rd_n;
            ia = st_q.flt.addr_mode_pin ? st_q.ptr : base;
            st_d.acc = act;
            st_d.poe = act & isrd;
            if (act && !st_q.acc) begin
                st_d.aw = ~isrd;
                if (isrd && st_q.flt.addr_mode_pin && !base[0]) begin
                    st_d.pdo = st_q.ptr;
                end else if (isrd) begin
                    ird = 1'b1;
                end
            end else if (!act && st_q.acc && st_q.aw) begin
                // data taken as it stood while the strobe was still active
                if (st_q.flt.addr_mode_pin && !base[0]) begin
                    st_d.ptr = st_q.prv.ad;
                end else begin
                    iwr = 1'b1;
                    idat = st_q.prv.ad;
                end
            end
        end
        // register request towards the chip
        st_d.q.we = iwr;
        st_d.q.re = ird;
        if (ird || iwr) begin
            st_d.q.addr = ia;
            st_d.q.wdata = idat;
            st_d.q.slot = st_q.fptr;
            st_d.q.fifo = serial_sel && ht == hp_pkg::HDR_CONST &&
                          (ia <= hp_pkg::FIFO_TOP || ia == hp_pkg::FIFO_AL0 ||
                           ia == hp_pkg::FIFO_AL1);
            st_d.ld = ird;
        end
        // watchdog
        wd_f = st_q.wd_on && st_q.wd_cnt == 23'(WDOG_LIM_CYC - 1);
        wd_sel = st_q.q.we && st_q.q.addr == hp_pkg::CFG_ADDR &&
                 st_q.q.wdata[1:0] == hp_pkg::SEL_WDOG;
        if (st_q.wd_on) begin
            st_d.wd_cnt = st_q.wd_cnt + 23'h1;
        end
        if (st_q.q.we) begin
            case (st_q.q.addr)
                hp_pkg::MASK_ADDR: st_d.mask = st_q.q.wdata;
                hp_pkg::CFG_ADDR:  st_d.cfg = st_q.q.wdata[2:0];
                hp_pkg::WDOG_ADDR: begin
                    // keys only count in order: step1 then step2
                    st_d.wd_arm = st_q.q.wdata[1:0] == hp_pkg::KEY_STEP1;
                    if (st_q.wd_arm && st_q.q.wdata[1:0] == hp_pkg::KEY_STEP2) begin
                        st_d.wd_cnt = 23'h0;
                    end
                end
                default: ;
            endcase
        end
        if (wd_sel) begin
            st_d.wd_on = 1'b1;
            st_d.wd_cnt = 23'h0;
            st_d.wd_arm = 1'b0;
        end
        if (st_q.q.re && st_q.q.addr == hp_pkg::TOP_IRQ_STATUS_ADDR) begin
            st_d.wdog_overflow_flag = 1'b0;
        end
        if (wd_f) begin
            st_d.wdog_overflow_flag = 1'b1;
            st_d.wd_cnt = 23'h0;
        end
        // reset sources
        st_d.ci = ci_code;
        cic_f = warm && ci_code != st_q.ci;
        wake_f = warm && st_q.prv.wake_n && !st_q.flt.wake_n;
        st_d.osc = wake_f;
        fire = cic_f | wake_f | wd_f;
        route = (st_q.cfg[1:0] == hp_pkg::SEL_CIW && (cic_f || wake_f)) || wd_f;
        if (fire) begin
            st_d.cfg = hp_pkg::CFG_RST;
        end
        if (route) begin
            st_d.rp = 13'(RST_PULSE_CYC);
        end else if (st_q.rp != 13'h0) begin
            st_d.rp = st_q.rp - 13'h1;
        end
        st_d.rst_n = st_d.rp == 13'h0;
        // polarity applied in the flop so the pin never glitches
        st_d.irq = st_q.cfg[hp_pkg::POL_BIT] ? pend : ~pend;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.irq <= 1'b1;
            st_q.mask <= hp_pkg::MASK_RST;
            st_q.cfg <= hp_pkg::CFG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign serial_data_out = st_q.serial_data_out;
    assign ad_out = st_q.pdo;
    assign ad_oe = st_q.poe;
    assign irq_pin = st_q.irq;
    assign reset_output_n = st_q.rst_n;
    assign osc_restart = st_q.osc;
    assign reg_req = st_q.q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_mux_sticky:
    assert property (st_q.mux_lk |=> st_q.mux_lk) else $error("mux style lock released");
    a_ale_lock:
    assert property (ale_e |=> st_q.mux_lk) else $error("ale edge did not lock mux style");
    a_irq_pending:
    assert property (pend |=> irq_pin == $past(st_q.cfg[2])) else $error("irq not active");
    a_irq_masked:
    assert property (!pend |=> irq_pin != $past(st_q.cfg[2])) else $error("masked irq shown");
    a_cfg_default:
    assert property (fire |=> st_q.cfg == hp_pkg::CFG_RST) else $error("config not defaulted");
    a_rst_routed:
    assert property (route |=> !reset_output_n ##1 !reset_output_n)
        else $error("routed reset pulse missing");
    a_rst_none:
    assert property (fire && !route && st_q.rp == 13'h0 |=> reset_output_n)
        else $error("unrouted source reached reset output");
    a_wov_flag:
    assert property (wd_f |=> st_q.wdog_overflow_flag && !reset_output_n) else $error("watchdog expiry lost");
    a_wdog_stays:
    assert property (st_q.wd_on |=> st_q.wd_on) else $error("watchdog stopped");
    a_wdog_start:
    assert property (wd_sel && !wd_f |=> st_q.wd_on && st_q.wd_cnt == 23'h0)
        else $error("watchdog not started clear");
    a_cs_abort:
    assert property (cs_rise |=> st_q.ph == hp_pkg::PH_HDR && st_q.bc == 3'h0 &&
                                 st_q.fptr == 8'h00) else $error("chip select abort failed");

    c_route: cover property (route);
    c_mux_lock: cover property (ale_e);
    c_wdog_exp: cover property (wd_f);
    c_ser_write: cover property (st_q.ph == hp_pkg::PH_WR && st_q.q.we);
endmodule
`default_nettype wire

// *** dv/hp_host_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none
module hp_host_mdl (
    // clock and bus style: 0 separate strobes, 1 r/w plus strobe, 2 multiplexed
    input  wire logic             sys_clk,
    input  wire logic [1:0]       style,
    // device pins
    output var hp_pkg::hp_pins_t  pins,
    input  wire logic             serial_data_out,
    input  wire logic [7:0]       ad_out,
    input  wire logic             ad_oe
);
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic idle();
        pins      = '1;
        pins.ale  = (style === 2'h1);
        pins.addr_mode_pin = 1'b0;
        pins.ad   = 8'h00;
    endtask
    initial idle();
    task automatic set_addr_mode_pin(input logic m);
        pins.addr_mode_pin = m;
    endtask
    task automatic ser_bits(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            wait_n(1);
            pins.sclk = 1'b0;
            pins.serial_data_in  = b[i];
            wait_n(8);
            pins.sclk = 1'b1;
            r[i]      = serial_data_out;
            wait_n(7);
        end
    endtask
    task automatic ser_open();
        wait_n(1);
        pins.cs_n = 1'b0;
        wait_n(8);
    endtask
    task automatic ser_close();
        wait_n(8);
        pins.cs_n = 1'b1;
        // a released data line shows the inverse, never a held value
        pins.serial_data_in  = ~pins.serial_data_in;
        wait_n(12);
    endtask
    task automatic par_acc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                           output logic [7:0] r, output logic oe);
        wait_n(1);
        if (style == 2'h2) begin
            pins.ad  = a;
            pins.ale = 1'b1;
            wait_n(5);
            pins.ale = 1'b0;
            wait_n(5);
            pins.a   = 8'hFF;
        end else begin
            pins.a   = a;
        end
        pins.ad   = rd ? ~pins.ad : d;
        pins.wr_n = rd;
        wait_n(1);
        pins.cs_n = 1'b0;
        pins.rd_n = (style == 2'h1) ? 1'b0 : ~rd;
        wait_n(10);
        r         = ad_out;
        oe        = ad_oe;
        pins.cs_n = 1'b1;
        pins.rd_n = 1'b1;
        pins.wr_n = 1'b1;
        wait_n(8);
    endtask
    task automatic wake();
        wait_n(1);
        pins.wake_n = 1'b0;
        wait_n(10);
        pins.wake_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned PULSE = 8;
    localparam int unsigned WLIM  = 64;
    typedef struct packed {logic rd; logic [7:0] a; logic [7:0] d;} hp_row_t;
    logic             sys_clk, sys_rst, serial_sel, serial_data_out, ad_oe, irq_pin, reset_output_n;
    logic             osc_restart;
    logic [1:0]       style;
    logic [3:0]       ci_code;
    logic [7:0]       ad_out, irq_src, reg_rdata, r, r2;
    hp_pkg::hp_pins_t pins;
    hp_pkg::hp_req_t  reg_req, last_ev;
    hp_pkg::hp_req_t  evq[$];
    int               mismatches, n_compared, lo_cnt, rst_len, rst_pulses, osc_pulses;
    int               irq_falls;
    hp_row_t          rows [6] = '{'{1'b0, 8'h20, 8'h3C}, '{1'b1, 8'h20, 8'h00},
                                   '{1'b0, 8'h7F, 8'hFF}, '{1'b1, 8'h80, 8'h00},
                                   '{1'b0, 8'h00, 8'h00}, '{1'b1, 8'hF7, 8'h00}};
    hp_host_port #(.RST_PULSE_CYC(PULSE), .WDOG_LIM_CYC(WLIM)) hp_host_port_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .serial_sel(serial_sel), .pins(pins),
        .serial_data_out(serial_data_out), .ad_out(ad_out), .ad_oe(ad_oe), .irq_pin(irq_pin),
        .reset_output_n(reset_output_n), .osc_restart(osc_restart), .irq_src(irq_src),
        .ci_code(ci_code), .reg_rdata(reg_rdata), .reg_req(reg_req));
    hp_host_mdl hp_host_mdl_i (.sys_clk(sys_clk), .style(style), .pins(pins), .serial_data_out(serial_data_out),
        .ad_out(ad_out), .ad_oe(ad_oe));
    // chip-side register file: data derived from address so reads are predictable
    assign reg_rdata = reg_req.addr ^ 8'hA5;
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (reg_req.we === 1'b1 || reg_req.re === 1'b1) evq.push_back(reg_req);
        if (reset_output_n === 1'b0) begin
            lo_cnt <= lo_cnt + 1;
        end else if (lo_cnt != 0) begin
            rst_len    <= lo_cnt;
            rst_pulses <= rst_pulses + 1;
            lo_cnt     <= 0;
        end
        if (osc_restart === 1'b1) osc_pulses <= osc_pulses + 1;
    end
    always @(negedge irq_pin) irq_falls = irq_falls + 1;
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic chk_ev(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (evq.size() == 0) begin
            check(1'b0, "missing register request");
            return;
        end
        last_ev = evq.pop_front();
        check(last_ev.we === w && last_ev.re === !w && last_ev.addr === a &&
              (!w || last_ev.wdata === d), "register request mismatch");
    endtask
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        logic oe;
        hp_host_mdl_i.par_acc(1'b0, a, d, r, oe);
    endtask
    task automatic prd(input logic [7:0] a, input logic [7:0] e);
        logic oe;
        hp_host_mdl_i.par_acc(1'b1, a, 8'h00, r, oe);
        check(r === e && oe === 1'b1, "parallel read data");
    endtask
    task automatic sx(input logic [7:0] b);
        hp_host_mdl_i.ser_bits(b, 8, r);
    endtask
    task automatic do_reset(input logic ser, input logic [1:0] st);
        style      = st;
        @(negedge sys_clk);
        sys_rst    = 1'b1;
        serial_sel = ser;
        hp_host_mdl_i.idle();
        repeat (12) @(negedge sys_clk);
        check(reset_output_n === 1'b0, "reset not mirrored");
        sys_rst = 1'b0;
        repeat (10) @(negedge sys_clk);
        evq.delete();
        rst_pulses = 0;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        sys_rst    = 1'b1;
        serial_sel = 1'b0;
        style      = 2'h0;
        irq_src    = 8'h00;
        ci_code    = 4'h0;
        {mismatches, n_compared, lo_cnt, rst_len, rst_pulses, osc_pulses, irq_falls} = '0;
        do_reset(1'b0, 2'h0);
        check(irq_pin === 1'b1 && reset_output_n === 1'b1 && ad_oe === 1'b0, "reset state");
        for (int i = 0; i < 6; i++) begin
            if (rows[i].rd) begin
                prd(rows[i].a, rows[i].a ^ 8'hA5);
                chk_ev(1'b0, rows[i].a, 8'h00);
            end else begin
                pwr(rows[i].a, rows[i].d);
                chk_ev(1'b1, rows[i].a, rows[i].d);
            end
        end
        hp_host_mdl_i.set_addr_mode_pin(1'b1);
        pwr(8'hFE, 8'h33);
        pwr(8'hFF, 8'h44);
        prd(8'hFE, 8'h33);
        check(evq.size() != 0 && evq[0].we === 1'b1 && evq[0].addr === 8'h33 &&
              evq[0].wdata === 8'h44, "indirect");
        hp_host_mdl_i.set_addr_mode_pin(1'b0);
        irq_src = 8'hA6;
        prd(hp_pkg::TOP_IRQ_STATUS_ADDR, 8'hA6);
        check(irq_pin === 1'b0, "irq not active");
        pwr(hp_pkg::MASK_ADDR, 8'hFF);
        check(irq_pin === 1'b1, "mask all");
        irq_falls = 0;
        pwr(hp_pkg::MASK_ADDR, 8'h00);
        check(irq_pin === 1'b0 && irq_falls == 1, "fresh edge");
        pwr(hp_pkg::MASK_ADDR, 8'hA6);
        check(irq_pin === 1'b1, "selective mask");
        irq_src = 8'h01;
        repeat (4) @(negedge sys_clk);
        check(irq_pin === 1'b0, "unmasked source");
        irq_src = 8'h00;
        repeat (4) @(negedge sys_clk);
        check(irq_pin === 1'b1, "all cleared");
        pwr(hp_pkg::CFG_ADDR, 8'h04);
        check(irq_pin === 1'b0, "active high idle");
        irq_src = 8'h01;
        repeat (4) @(negedge sys_clk);
        check(irq_pin === 1'b1, "active high");
        irq_src = 8'h00;
        pwr(hp_pkg::MASK_ADDR, 8'h00);
        for (int s = 0; s < 3; s++) begin
            pwr(hp_pkg::CFG_ADDR, 8'(s));
            rst_pulses = 0;
            ci_code    = ci_code + 4'h1;
            repeat (30) @(negedge sys_clk);
            check(rst_pulses == (s == 2) && (s != 2 || rst_len == PULSE),
                  "code change");
            prd(hp_pkg::CFG_ADDR, 8'h00);
            check(s != 2 || rst_pulses == 1, "routing");
        end
        pwr(hp_pkg::CFG_ADDR, 8'h02);
        rst_pulses = 0;
        osc_pulses = 0;
        hp_host_mdl_i.wake();
        repeat (30) @(negedge sys_clk);
        check(osc_pulses == 1 && rst_pulses == 1 && rst_len == PULSE, "wake");
        pwr(hp_pkg::CFG_ADDR, 8'h03);
        rst_pulses = 0;
        repeat (4) begin
            pwr(hp_pkg::WDOG_ADDR, 8'h02);
            pwr(hp_pkg::WDOG_ADDR, 8'h01);
        end
        check(rst_pulses == 0, "keyed watchdog fired");
        pwr(hp_pkg::CFG_ADDR, 8'h00);
        repeat (90) @(negedge sys_clk);
        check(rst_pulses >= 1 && rst_len == PULSE, "watchdog expiry");
        prd(hp_pkg::TOP_IRQ_STATUS_ADDR, 8'h01);
        do_reset(1'b0, 2'h1);
        pwr(8'h31, 8'h4D);
        chk_ev(1'b1, 8'h31, 8'h4D);
        prd(8'h32, 8'h97);
        chk_ev(1'b0, 8'h32, 8'h00);
        style = 2'h2;
        pwr(8'h41, 8'h6E);
        chk_ev(1'b1, 8'h41, 8'h6E);
        style = 2'h0;
        pwr(8'h55, 8'h12);
        chk_ev(1'b1, 8'h41, 8'h12);
        do_reset(1'b0, 2'h0);
        pwr(8'h55, 8'h12);
        chk_ev(1'b1, 8'h55, 8'h12);
        do_reset(1'b1, 2'h0);
        hp_host_mdl_i.ser_open();
        sx(hp_pkg::HDR_CONST);
        sx(8'h05);
        for (int i = 0; i < 3; i++) sx(8'(8'h11 * (i + 1)));
        hp_host_mdl_i.ser_close();
        for (int i = 0; i < 3; i++) begin
            chk_ev(1'b1, 8'h05, 8'(8'h11 * (i + 1)));
            check(last_ev.fifo === 1'b1 && last_ev.slot === 8'(i), "fifo slot");
        end
        hp_host_mdl_i.ser_open();
        sx(hp_pkg::HDR_CONST);
        sx(8'h90);
        sx(8'hFF);
        r2 = r;
        sx(8'hFF);
        hp_host_mdl_i.ser_close();
        check(r2 === 8'hB5 && r === 8'hB5, "half select read");
        evq.delete();
        hp_host_mdl_i.ser_open();
        sx(hp_pkg::HDR_MIX_NI);
        sx(8'h82);
        sx(8'h00);
        r2 = r;
        sx(8'h03);
        sx(8'h5A);
        sx(8'h6B);
        hp_host_mdl_i.ser_close();
        check(r2 === 8'hA7, "non-interleaved read");
        chk_ev(1'b0, 8'h02, 8'h00);
        chk_ev(1'b1, 8'h03, 8'h5A);
        chk_ev(1'b1, 8'h03, 8'h6B);
        hp_host_mdl_i.ser_open();
        sx(hp_pkg::HDR_MIX_IL);
        sx(8'h85);
        sx(8'h86);
        r2 = r;
        sx(8'h03);
        check(r2 === 8'hA0 && r === 8'hA3, "interleaved read");
        sx(8'h7C);
        hp_host_mdl_i.ser_close();
        chk_ev(1'b0, 8'h05, 8'h00);
        chk_ev(1'b0, 8'h06, 8'h00);
        chk_ev(1'b1, 8'h03, 8'h7C);
        hp_host_mdl_i.ser_open();
        hp_host_mdl_i.ser_bits(hp_pkg::HDR_CONST, 4, r);
        hp_host_mdl_i.ser_close();
        hp_host_mdl_i.ser_open();
        sx(hp_pkg::HDR_CONST | 8'h04);
        sx(8'h27);
        sx(8'h99);
        hp_host_mdl_i.ser_close();
        chk_ev(1'b1, 8'hA7, 8'h99);
        check(evq.size() == 0, "extra request");
        stop_test();
    end
endmodule
`default_nettype wire
